// >>> shared/adir_pkg.sv
package adir_pkg;
  localparam int          ADIR_ADDR_W       = 32;
  localparam int          ADIR_DATA_W       = 32;
  localparam int          ADIR_REG_W        = 16;
  localparam int          ADIR_SRC_N        = 8;
  // Byte addresses of the registers
  localparam logic [31:0] ADIR_CLEAR_OFS    = 32'h4008_3004;
  localparam logic [31:0] ADIR_SELECT_OFS   = 32'h4008_3008;
  localparam logic [31:0] ADIR_STATUS_OFS   = 32'h4008_300C;
  // Reset values
  localparam logic [15:0] ADIR_CLEAR_RST    = 16'h0000;
  localparam logic [15:0] ADIR_SELECT_RST   = 16'h0000;
  localparam logic [15:0] ADIR_STATUS_RST   = 16'h0000;
  // Source bit positions, shared by clear, status and both select bytes
  localparam int          ADIR_BIT_SOFTCONV = 0;
  localparam int          ADIR_BIT_SEQ      = 1;
  localparam int          ADIR_BIT_COMP     = 2;
  localparam int          ADIR_BIT_RSVD     = 3;
  localparam int          ADIR_BIT_THERMAL  = 4;
  localparam int          ADIR_BIT_EXTRES   = 5;
  localparam int          ADIR_BIT_RDCHK    = 6;
  localparam int          ADIR_BIT_WRCHK    = 7;
  localparam int          ADIR_LINE1_LSB    = 0;
  localparam int          ADIR_LINE0_LSB    = 8;
  // Sources that exist; bit 3 is reserved
  localparam logic [7:0]  ADIR_SRC_MASK     = 8'hF7;
  // AXI responses
  localparam logic [1:0]  ADIR_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  ADIR_RESP_SLVERR  = 2'h2;
endpackage

// >>> rtl/adir_flags.sv
`timescale 1ns/1ps
module adir_flags
  import adir_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] event_in,
  input  wire logic [N-1:0] clear_in,
  input  wire logic [N-1:0] valid_mask,
  output logic      [N-1:0] flag
);
  if (N < 1) begin : g_bad_n
    $error("adir_flags: N must be positive");
  end

  generate
    for (genvar i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flag[i] <= 1'b0;
        end else if (!valid_mask[i]) begin
          flag[i] <= 1'b0;
        end else if (event_in[i]) begin
          flag[i] <= 1'b1;  // Set beats a clear in the same cycle
        end else if (clear_in[i]) begin
          flag[i] <= 1'b0;
        end
      end

      a_flag_set_wins : assert property (@(posedge clk) disable iff (!rst_n)
        valid_mask[i] && event_in[i] |=> flag[i])
        else $error("flag not set after event");
      a_flag_clears : assert property (@(posedge clk) disable iff (!rst_n)
        clear_in[i] && !event_in[i] |=> !flag[i])
        else $error("flag not cleared");
      a_flag_holds : assert property (@(posedge clk) disable iff (!rst_n)
        flag[i] && !clear_in[i] && valid_mask[i] |=> flag[i])
        else $error("flag dropped without clear");
    end
  endgenerate
endmodule

// >>> rtl/adir_router.sv
`timescale 1ns/1ps
module adir_router
(
  input  wire logic                          CLK,
  input  wire logic                          RST_B,
  input  wire logic                          SOFT_CONV_DONE,
  input  wire logic                          SOFT_CONV_EN,
  input  wire logic                          SEQUENCE_DONE,
  input  wire logic                          COMPARATOR_TRIP,
  input  wire logic                          THERMAL_SHUTDOWN,
  input  wire logic                          EXT_RESISTOR_FAULT,
  input  wire logic                          READ_CHECK_ERROR,
  input  wire logic                          WRITE_CHECK_ERROR,
  output logic                               ANALOG_IRQ_LINE_ZERO,
  output logic                               ANALOG_IRQ_LINE_ONE,
  input  wire logic [adir_pkg::ADIR_ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [adir_pkg::ADIR_DATA_W-1:0]   S_AXI_WDATA,
  input  wire logic [adir_pkg::ADIR_DATA_W/8-1:0] S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic      [1:0]                    S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [adir_pkg::ADIR_ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic      [adir_pkg::ADIR_DATA_W-1:0]   S_AXI_RDATA,
  output logic      [1:0]                    S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY
);
  import adir_pkg::*;

  logic        rst_meta;
  logic        rst_n;
  logic [31:0] aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic [15:0] select;
  logic [7:0]  events;
  logic [7:0]  clear_req;
  logic [7:0]  flag;
  logic        do_write;

  // Bit map is fixed: eight source slots in 16-bit registers
  if (ADIR_SRC_N != 8 || ADIR_REG_W != 16) begin : g_bad_size
    $error("adir_router: source map needs 8 sources and 16-bit registers");
  end

  // Reset released through two flops; asynchronous assert
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Event gathering, one bit per source in clear-register order
  always_comb begin
    events                    = 8'h00;
    events[ADIR_BIT_SOFTCONV] = SOFT_CONV_DONE && SOFT_CONV_EN;
    events[ADIR_BIT_SEQ]      = SEQUENCE_DONE;
    events[ADIR_BIT_COMP]     = COMPARATOR_TRIP;
    events[ADIR_BIT_THERMAL]  = THERMAL_SHUTDOWN;
    events[ADIR_BIT_EXTRES]   = EXT_RESISTOR_FAULT;
    events[ADIR_BIT_RDCHK]    = READ_CHECK_ERROR;
    events[ADIR_BIT_WRCHK]    = WRITE_CHECK_ERROR;
  end

  adir_flags #(
    .N (ADIR_SRC_N)
  ) u_flags (
    .clk        (CLK),
    .rst_n      (rst_n),
    .event_in   (events),
    .clear_in   (clear_req),
    .valid_mask (ADIR_SRC_MASK),
    .flag       (flag)
  );

  // Write address and data accepted in either order
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held       <= 1'b1;
      aw_addr       <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (do_write) begin
      aw_held       <= 1'b0;
    end else if (!aw_held && !S_AXI_BVALID) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held       <= 1'b1;
      w_data       <= S_AXI_WDATA;
      w_strb       <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else if (do_write) begin
      w_held       <= 1'b0;
    end else if (!w_held && !S_AXI_BVALID) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  assign do_write = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= ADIR_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (aw_addr == ADIR_CLEAR_OFS || aw_addr == ADIR_SELECT_OFS)
                      ? ADIR_RESP_OKAY : ADIR_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Select register; reserved bits 11 and 3 forced to zero
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      select <= ADIR_SELECT_RST;
    end else if (do_write && aw_addr == ADIR_SELECT_OFS) begin
      if (w_strb[0]) begin
        select[7:0]  <= w_data[7:0] & ADIR_SRC_MASK;
      end
      if (w_strb[1]) begin
        select[15:8] <= w_data[15:8] & ADIR_SRC_MASK;
      end
    end
  end

  // Clear is a one-cycle pulse; writing 0 leaves the flag
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      clear_req <= ADIR_CLEAR_RST[7:0];
    end else if (do_write && aw_addr == ADIR_CLEAR_OFS && w_strb[0]) begin
      clear_req <= w_data[7:0] & ADIR_SRC_MASK;
    end else begin
      clear_req <= 8'h00;
    end
  end

  // Read channel; clear register reads as zero since it is write-only
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= ADIR_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= ADIR_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        ADIR_SELECT_OFS: S_AXI_RDATA <= {16'h0000, select};
        ADIR_STATUS_OFS: S_AXI_RDATA <= {24'h00_0000, flag};
        ADIR_CLEAR_OFS:  S_AXI_RDATA <= 32'h0000_0000;
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= ADIR_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Both lines are registered; line zero does not police one-hot use
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ANALOG_IRQ_LINE_ZERO <= 1'b0;
      ANALOG_IRQ_LINE_ONE  <= 1'b0;
    end else begin
      ANALOG_IRQ_LINE_ZERO <= |(flag & select[15:8]);
      ANALOG_IRQ_LINE_ONE  <= |(flag & select[7:0]);
    end
  end

  a_line_one_follows : assert property (@(posedge CLK) disable iff (!rst_n)
    ANALOG_IRQ_LINE_ONE == $past(|(flag & select[7:0])))
    else $error("line one mismatch");
  a_line_zero_follows : assert property (@(posedge CLK) disable iff (!rst_n)
    ANALOG_IRQ_LINE_ZERO == $past(|(flag & select[15:8])))
    else $error("line zero mismatch");
  a_clear_drops_flag : assert property (@(posedge CLK) disable iff (!rst_n)
    do_write && aw_addr == ADIR_CLEAR_OFS && w_strb[0] && w_data[0]
      && !events[0] ##1 !events[0] |=> !flag[0])
    else $error("clear did not drop flag");
  a_event_raises_line : assert property (@(posedge CLK) disable iff (!rst_n)
    events[ADIR_BIT_WRCHK] && select[ADIR_BIT_WRCHK] ##1 select[ADIR_BIT_WRCHK]
      |=> ANALOG_IRQ_LINE_ONE)
    else $error("line one not raised");
  a_reserved_zero : assert property (@(posedge CLK) disable iff (!rst_n)
    !flag[ADIR_BIT_RSVD] && !select[ADIR_BIT_RSVD] && !select[11])
    else $error("reserved bit set");
  a_softconv_gated : assert property (@(posedge CLK) disable iff (!rst_n)
    !flag[0] && !SOFT_CONV_EN && !clear_req[0] |=> !flag[0])
    else $error("softconv set while disabled");
  a_status_read : assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADIR_STATUS_OFS
      |=> S_AXI_RVALID && S_AXI_RDATA[7:0] == $past(flag))
    else $error("status read wrong");
  a_bresp_once : assert property (@(posedge CLK) disable iff (!rst_n)
    do_write |=> S_AXI_BVALID)
    else $error("no write response");

  // Pin to flag wiring for soft conversion, comparator and read check only, then register and bus checks
  a_softconv_sets : assert property (@(posedge CLK) disable iff (!rst_n)
    SOFT_CONV_DONE && SOFT_CONV_EN |=> flag[ADIR_BIT_SOFTCONV])
    else $error("softconv flag not set");
  a_comparator_sets : assert property (@(posedge CLK) disable iff (!rst_n)
    COMPARATOR_TRIP |=> flag[ADIR_BIT_COMP])
    else $error("comparator flag not set");
  a_rdchk_sets : assert property (@(posedge CLK) disable iff (!rst_n)
    READ_CHECK_ERROR |=> flag[ADIR_BIT_RDCHK])
    else $error("read check flag not set");
  a_clear_one_shot : assert property (@(posedge CLK) disable iff (!rst_n)
    |clear_req |=> clear_req == 8'h00)
    else $error("clear pulse too long");
  a_clear_idle_zero : assert property (@(posedge CLK) disable iff (!rst_n)
    !(do_write && aw_addr == ADIR_CLEAR_OFS) |=> clear_req == 8'h00)
    else $error("clear without clear write");
  a_select_low_write : assert property (@(posedge CLK) disable iff (!rst_n)
    do_write && aw_addr == ADIR_SELECT_OFS && w_strb[0]
      |=> select[7:0] == ($past(w_data[7:0]) & ADIR_SRC_MASK))
    else $error("select low byte not written");
  a_select_high_write : assert property (@(posedge CLK) disable iff (!rst_n)
    do_write && aw_addr == ADIR_SELECT_OFS && w_strb[1]
      |=> select[15:8] == ($past(w_data[15:8]) & ADIR_SRC_MASK))
    else $error("select high byte not written");
  a_select_stable : assert property (@(posedge CLK) disable iff (!rst_n)
    !(do_write && aw_addr == ADIR_SELECT_OFS) |=> $stable(select))
    else $error("select changed without write");
  a_status_no_write : assert property (@(posedge CLK) disable iff (!rst_n)
    do_write && aw_addr != ADIR_CLEAR_OFS && aw_addr != ADIR_SELECT_OFS
      |=> S_AXI_BRESP == ADIR_RESP_SLVERR)
    else $error("write to read-only space accepted");
  a_select_read : assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADIR_SELECT_OFS
      |=> S_AXI_RDATA == {16'h0000, $past(select)})
    else $error("select read wrong");
  a_clear_reads_zero : assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADIR_CLEAR_OFS
      |=> S_AXI_RDATA == 32'h0000_0000)
    else $error("clear register read not zero");
  a_read_unmapped : assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR != ADIR_CLEAR_OFS
      && S_AXI_ARADDR != ADIR_SELECT_OFS && S_AXI_ARADDR != ADIR_STATUS_OFS
      |=> S_AXI_RRESP == ADIR_RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_bvalid_holds : assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_rvalid_holds : assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_awready_busy : assert property (@(posedge CLK) disable iff (!rst_n)
    aw_held |-> !S_AXI_AWREADY)
    else $error("address ready while one is held");
  a_wready_busy : assert property (@(posedge CLK) disable iff (!rst_n)
    w_held |-> !S_AXI_WREADY)
    else $error("data ready while one is held");
  a_arready_busy : assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address ready during response");

  c_line_one : cover property (@(posedge CLK) disable iff (!rst_n)
    ANALOG_IRQ_LINE_ONE);
  c_line_zero : cover property (@(posedge CLK) disable iff (!rst_n)
    ANALOG_IRQ_LINE_ZERO);
  c_clear_write : cover property (@(posedge CLK) disable iff (!rst_n)
    |clear_req);
  c_both_lines : cover property (@(posedge CLK) disable iff (!rst_n)
    ANALOG_IRQ_LINE_ZERO && ANALOG_IRQ_LINE_ONE);
  c_unmapped_read : cover property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_RVALID && S_AXI_RRESP == ADIR_RESP_SLVERR);
endmodule

// >>> tb/adir_irq_sink.sv
`timescale 1ns/1ps
module adir_irq_sink (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic line_zero,
  input  wire logic line_one,
  input  wire logic ack,
  output logic      seen_zero,
  output logic      seen_one
);
  // Sticky, so a line that drops again before software looks is not lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_zero <= 1'b0;
      seen_one  <= 1'b0;
    end else if (ack) begin
      seen_zero <= 1'b0;
      seen_one  <= 1'b0;
    end else begin
      seen_zero <= seen_zero | line_zero;
      seen_one  <= seen_one | line_one;
    end
  end
endmodule

// >>> tb/analog_die_irq_router_tb_top.sv
`timescale 1ns/1ps
module analog_die_irq_router_tb_top;
  import adir_pkg::*;
  logic        clk, rst_b, en, ack, line0, line1, seen0, seen1;
  logic [7:0]  ev;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0]  wstrb, ws;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  int          miscompares, n_checks, cyc, s;
  int          srcs[7] = '{0, 1, 2, 4, 5, 6, 7};

  adir_router i_dut (.CLK(clk), .RST_B(rst_b), .SOFT_CONV_DONE(ev[0]), .SOFT_CONV_EN(en),
    .SEQUENCE_DONE(ev[1]), .COMPARATOR_TRIP(ev[2]), .THERMAL_SHUTDOWN(ev[4]),
    .EXT_RESISTOR_FAULT(ev[5]), .READ_CHECK_ERROR(ev[6]), .WRITE_CHECK_ERROR(ev[7]),
    .ANALOG_IRQ_LINE_ZERO(line0), .ANALOG_IRQ_LINE_ONE(line1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  adir_irq_sink i_sink (.clk(clk), .rst_n(rst_b), .line_zero(line0), .line_one(line1),
    .ack(ack), .seen_zero(seen0), .seen_one(seen1));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic test_done;
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= ws;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    // Ready stays up, so a following call never flips it in the same step
    r = bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    rst_b = 1'b0; en = 1'b1; ack = 1'b0; ev = 8'h00; wstrb = 4'hF;
    ws = 4'hF;
    awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    miscompares = 0; n_checks = 0; cyc = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADIR_SELECT_OFS);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, ADIR_RESP_OKAY});
    rd(ADIR_STATUS_OFS);
    chk(d, 32'h0000_0000);
    wr(ADIR_SELECT_OFS, 32'hFFFF_FFFF);
    chk({30'h0, r}, {30'h0, ADIR_RESP_OKAY});
    rd(ADIR_SELECT_OFS);
    chk(d, 32'h0000_F7F7);
    // High byte only: the low byte must keep its enables
    ws = 4'h2;
    wr(ADIR_SELECT_OFS, 32'h0000_0000);
    ws = 4'hF;
    rd(ADIR_SELECT_OFS);
    chk(d, 32'h0000_00F7);
    rd(ADIR_CLEAR_OFS);
    chk(d, 32'h0000_0000);
    wr(ADIR_STATUS_OFS, 32'h0000_00FF);
    chk({30'h0, r}, {30'h0, ADIR_RESP_SLVERR});
    rd(ADIR_STATUS_OFS);
    chk(d, 32'h0000_0000);
    rd(32'h4008_3010);
    chk({30'h0, r}, {30'h0, ADIR_RESP_SLVERR});
    // Line zero gets the comparator alone, as software must keep it one-hot
    wr(ADIR_SELECT_OFS, 32'h0000_04F7);
    foreach (srcs[k]) begin
      s = srcs[k];
      pulse(8'h01 << s);
      chk({31'h0, line1}, 32'h1);
      chk({31'h0, line0}, {31'h0, s == 2});
      rd(ADIR_STATUS_OFS);
      chk(d, 32'h1 << s);
      wr(ADIR_CLEAR_OFS, 32'h0);
      rd(ADIR_STATUS_OFS);
      chk(d, 32'h1 << s);
      wr(ADIR_CLEAR_OFS, 32'h1 << s);
      rd(ADIR_STATUS_OFS);
      chk(d, 32'h0);
      chk({31'h0, line1}, 32'h0);
    end
    chk({30'h0, seen0, seen1}, 32'h3);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    wr(ADIR_SELECT_OFS, 32'h0000_0001);
    pulse(8'h10);
    chk({31'h0, line1}, 32'h0);
    rd(ADIR_STATUS_OFS);
    chk(d, 32'h0000_0010);
    wr(ADIR_CLEAR_OFS, 32'h0000_0010);
    en <= 1'b0;
    pulse(8'h01);
    rd(ADIR_STATUS_OFS);
    chk(d, 32'h0);
    chk({31'h0, line1}, 32'h0);
    chk({30'h0, seen0, seen1}, 32'h0);
    test_done();
  end
endmodule
